// ### status_readout_map.svh
`ifndef STATUS_READOUT_MAP_SVH
`define STATUS_READOUT_MAP_SVH
// Overview of operation
// R1: group select uses 000b, 001b, 010b, 101b only
// R2: 16-bit status word chosen by group and function
// R3: index 0-1 physical, 2-7 virtual functions
// R4: user places index, then asserts request
// R5: request presents selected function's values
// R6: completion pulses exactly one clock cycle
// R7: bit 0 io enable; endpoint filters io as UR
// R8: root ignores enables; user gates downstream traffic
// R9: bit 1 memory enable; endpoint filters memory as UR
// R10: bit 2 bus master; user requests only when set
// R11: root port user ignores bus master bit
// R12: bit 3 interrupt disable blocks legacy INTx
// R13: bit 4 serr or device control enables reporting
// R14: root forwards secondary errors only with serr
// R15: user holds inputs until completion, samples after

// ----------------------------------------
// readout port geometry
// ----------------------------------------
`define FN_W 3
`define GRP_W 3
`define DATA_W 16
`define FN_COUNT 8
`define PF_COUNT 2

// ----------------------------------------
// group select encodings
// ----------------------------------------
`define GRP_COMMAND 3'h0
`define GRP_DEVICE 3'h1
`define GRP_TWO 3'h2
`define GRP_FIVE 3'h5

// ----------------------------------------
// command field positions and reset values
// ----------------------------------------
`define CMD_W 5
`define CMD_IO_BIT 0
`define CMD_MEM_BIT 1
`define CMD_BME_BIT 2
`define CMD_INTX_DIS_BIT 3
`define CMD_SERR_BIT 4
`define CMD_RST 5'h00
`define DEVCTL_W 2
`define DEVCTL_NF_BIT 0
`define DEVCTL_FATAL_BIT 1
`define DEVCTL_RST 2'h0
`define DEVCTL_LSB 5
`endif

// ### status_readout_pkg.sv
package status_readout_pkg;
`include "status_readout_map.svh"

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_DONE = 2'b01,
        DEV_HOLD = 2'b10
    } dev_state_t;

    typedef enum logic [0:0] {
        USR_IDLE = 1'b0,
        USR_REQ = 1'b1
    } usr_state_t;

    // ----------------------------------------
    // group decode shared by both ends
    // ----------------------------------------
    function automatic logic grp_reserved(input logic [`GRP_W-1:0] g);
        grp_reserved = !(g == `GRP_COMMAND || g == `GRP_DEVICE ||
            g == `GRP_TWO || g == `GRP_FIVE);
    endfunction
endpackage

// ### status_readout_if.sv
`timescale 1ns/1ps
`include "status_readout_map.svh"
interface status_readout_if;
    logic [`GRP_W-1:0] group_sel;
    logic [`FN_W-1:0] func_num;
    logic request;
    logic [`DATA_W-1:0] status_data;
    logic update_done;

    modport dev (
        input group_sel,
        input func_num,
        input request,
        output status_data,
        output update_done
    );

    modport usr (
        output group_sel,
        output func_num,
        output request,
        input status_data,
        input update_done
    );
endinterface

// ### status_readout_dev.sv
`timescale 1ns/1ps
`include "status_readout_map.svh"
module status_readout_dev
    import status_readout_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CE,
    status_readout_if.dev PORT,
    input wire logic ROOT_MODE,
    input wire logic CFG_WR,
    input wire logic [`FN_W-1:0] CFG_WR_FN,
    input wire logic [`CMD_W-1:0] CFG_WR_CMD,
    input wire logic [`DEVCTL_W-1:0] CFG_WR_DEVCTL,
    input wire logic RX_REQ,
    input wire logic RX_IS_IO,
    input wire logic [`FN_W-1:0] RX_FN,
    output logic RX_ACCEPT,
    output logic RX_UR,
    input wire logic INTX_REQ,
    input wire logic [`FN_W-1:0] INTX_FN,
    output logic INTX_ASSERT,
    input wire logic ERR_NF_EV,
    input wire logic ERR_FATAL_EV,
    input wire logic ERR_FWD,
    input wire logic [`FN_W-1:0] ERR_FN,
    output logic ERR_NF_MSG,
    output logic ERR_FATAL_MSG
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        dev_state_t state;
        logic [`FN_COUNT-1:0][`CMD_W-1:0] cmd;
        logic [`FN_COUNT-1:0][`DEVCTL_W-1:0] devctl;
        logic [`DATA_W-1:0] data;
        logic accept;
        logic ur;
        logic intx;
        logic nf_msg;
        logic fatal_msg;
    } dev_regs_t;

    dev_regs_t state_reg;
    dev_regs_t state_next;

    // ----------------------------------------
    // status word builder
    // ----------------------------------------
    // R2 group and function
    function automatic logic [`DATA_W-1:0] status_word(
        input logic [`GRP_W-1:0] g,
        input logic [`CMD_W-1:0] c,
        input logic [`DEVCTL_W-1:0] d
    );
        logic [`DATA_W-1:0] w;
        w = '0;
        if (grp_reserved(g))
        begin
            w = '0;
        end
        else if (g == `GRP_COMMAND)
        begin
            w[`CMD_W-1:0] = c;
        end
        else if (g == `GRP_DEVICE)
        begin
            // reporting enables sit above the status bits
            w[`DEVCTL_LSB + `DEVCTL_W - 1:`DEVCTL_LSB] = d;
        end
        status_word = w;
    endfunction

    // R13 serr or devctl
    function automatic logic report_ok(
        input logic [`CMD_W-1:0] c,
        input logic devbit
    );
        report_ok = c[`CMD_SERR_BIT] | devbit;
    endfunction

    logic [`CMD_W-1:0] rx_cmd;
    logic [`CMD_W-1:0] err_cmd;
    logic [`DEVCTL_W-1:0] err_dev;
    logic space_on;

    always_comb
    begin
        rx_cmd = state_reg.cmd[RX_FN];
        err_cmd = state_reg.cmd[ERR_FN];
        err_dev = state_reg.devctl[ERR_FN];
        space_on = RX_IS_IO ? rx_cmd[`CMD_IO_BIT] : rx_cmd[`CMD_MEM_BIT];
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.accept = 1'b0;
        state_next.ur = 1'b0;
        state_next.nf_msg = 1'b0;
        state_next.fatal_msg = 1'b0;

        // R3 index pf then vf
        // config writes land per function, index maps pf then vf
        if (CFG_WR)
        begin
            state_next.cmd[CFG_WR_FN] = CFG_WR_CMD;
            state_next.devctl[CFG_WR_FN] = CFG_WR_DEVCTL;
        end

        // incoming request filtering
        if (RX_REQ)
        begin
            if (ROOT_MODE)
            begin
                // R8 root ignores enables
                state_next.accept = 1'b1;
            end
            else if (space_on)
            begin
                state_next.accept = 1'b1;
            end
            else
            begin
                // R7 io filtered UR
                // R9 memory filtered UR
                state_next.ur = 1'b1;
            end
        end

        // R12 intx disable gate
        state_next.intx = INTX_REQ &
            ~state_reg.cmd[INTX_FN][`CMD_INTX_DIS_BIT];

        // error message generation
        if (ERR_FWD)
        begin
            // R14 root forwards with serr
            // endpoints have no secondary side, so forwarded ones drop
            if (ROOT_MODE && err_cmd[`CMD_SERR_BIT])
            begin
                state_next.nf_msg = ERR_NF_EV;
                state_next.fatal_msg = ERR_FATAL_EV;
            end
        end
        else
        begin
            // R13 either enable reports
            state_next.nf_msg = ERR_NF_EV &
                report_ok(err_cmd, err_dev[`DEVCTL_NF_BIT]);
            state_next.fatal_msg = ERR_FATAL_EV &
                report_ok(err_cmd, err_dev[`DEVCTL_FATAL_BIT]);
        end

        // readout handshake
        unique case (state_reg.state)
            DEV_IDLE:
            begin
                if (PORT.request)
                begin
                    // R5 present selected function
                    state_next.data = status_word(PORT.group_sel,
                        state_reg.cmd[PORT.func_num],
                        state_reg.devctl[PORT.func_num]);
                    state_next.state = DEV_DONE;
                end
            end
            DEV_DONE:
            begin
                // R6 single cycle done
                state_next.state = DEV_HOLD;
            end
            DEV_HOLD:
            begin
                // a held request must not retrigger a second pulse
                if (!PORT.request)
                begin
                    state_next.state = DEV_IDLE;
                end
            end
            default:
            begin
                state_next.state = DEV_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_reg <= '0;
            state_reg.state <= DEV_IDLE;
            for (int i = 0; i < `FN_COUNT; i++)
            begin
                state_reg.cmd[i] <= `CMD_RST;
                state_reg.devctl[i] <= `DEVCTL_RST;
            end
        end
        else if (CE)
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign PORT.status_data = state_reg.data;
    assign PORT.update_done = (state_reg.state == DEV_DONE);
    assign RX_ACCEPT = state_reg.accept;
    assign RX_UR = state_reg.ur;
    assign INTX_ASSERT = state_reg.intx;
    assign ERR_NF_MSG = state_reg.nf_msg;
    assign ERR_FATAL_MSG = state_reg.fatal_msg;

endmodule // status_readout_dev

// ### status_readout_usr.sv
`timescale 1ns/1ps
`include "status_readout_map.svh"
module status_readout_usr
    import status_readout_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CE,
    status_readout_if.usr PORT,
    input wire logic ROOT_MODE,
    input wire logic RD_START,
    input wire logic [`FN_W-1:0] RD_FN,
    input wire logic [`GRP_W-1:0] RD_GROUP,
    output logic RD_BUSY,
    output logic RD_VALID,
    output logic RD_REFUSED,
    output logic [`DATA_W-1:0] RD_DATA,
    output logic IO_TLP_OK,
    output logic MEM_TLP_OK,
    output logic MASTER_OK
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        usr_state_t state;
        logic [`FN_W-1:0] fn;
        logic [`GRP_W-1:0] grp;
        logic [`DATA_W-1:0] data;
        logic valid;
        logic refused;
        logic [`CMD_W-1:0] cmd;
    } usr_regs_t;

    usr_regs_t state_reg;
    usr_regs_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.valid = 1'b0;
        state_next.refused = 1'b0;
        unique case (state_reg.state)
            USR_IDLE:
            begin
                if (RD_START)
                begin
                    // R1 reserved groups refused
                    if (grp_reserved(RD_GROUP))
                    begin
                        state_next.refused = 1'b1;
                    end
                    else
                    begin
                        // R4 index then request
                        state_next.fn = RD_FN;
                        state_next.grp = RD_GROUP;
                        state_next.state = USR_REQ;
                    end
                end
            end
            USR_REQ:
            begin
                // R15 sample after done
                if (PORT.update_done)
                begin
                    state_next.data = PORT.status_data;
                    state_next.valid = 1'b1;
                    if (state_reg.grp == `GRP_COMMAND)
                    begin
                        state_next.cmd = PORT.status_data[`CMD_W-1:0];
                    end
                    state_next.state = USR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_reg <= '0;
            state_reg.state <= USR_IDLE;
            state_reg.cmd <= `CMD_RST;
        end
        else if (CE)
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // R15 held stable until done
    assign PORT.func_num = state_reg.fn;
    assign PORT.group_sel = state_reg.grp;
    assign PORT.request = (state_reg.state == USR_REQ);
    assign RD_BUSY = (state_reg.state != USR_IDLE);
    assign RD_VALID = state_reg.valid;
    assign RD_REFUSED = state_reg.refused;
    assign RD_DATA = state_reg.data;
    // R8 downstream gated by enables
    assign IO_TLP_OK = state_reg.cmd[`CMD_IO_BIT];
    assign MEM_TLP_OK = state_reg.cmd[`CMD_MEM_BIT];
    // R10 bus master gate
    // R11 root ignores bus master
    assign MASTER_OK = ROOT_MODE | state_reg.cmd[`CMD_BME_BIT];

endmodule // status_readout_usr

// ### status_readout_chk.sv
`timescale 1ns/1ps
`include "status_readout_map.svh"
module status_readout_chk (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic [`GRP_W-1:0] group_sel,
    input wire logic [`FN_W-1:0] func_num,
    input wire logic request,
    input wire logic [`DATA_W-1:0] status_data,
    input wire logic update_done
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    // ----------------------------------------
    // handshake timing
    // ----------------------------------------
    property p_done_pulse;
        update_done |=> !update_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done wider than one cycle");
    property p_req_done;
        $rose(request) |=> update_done;
    endproperty
    a_req_done: assert property (p_req_done)
        else $error("no done one cycle after request");
    property p_done_cause;
        update_done |-> $past(request);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done without request");
    property p_req_hold;
        $rose(request) |=> request && $stable(func_num) && $stable(group_sel);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request inputs moved before done");
    property p_req_drop;
        update_done |=> !request;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request still high after done");
    // word must stand in the cycle after done
    property p_data_hold;
        update_done ##1 !request |-> $stable(status_data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("status word changed while idle");

    // ----------------------------------------
    // word layout per group
    // ----------------------------------------
    property p_grp0;
        $rose(request) && group_sel == `GRP_COMMAND
            |=> status_data[15:5] == 11'h000;
    endproperty
    a_grp0: assert property (p_grp0)
        else $error("group 0 upper bits not zero");
    property p_grp1;
        $rose(request) && group_sel == `GRP_DEVICE
            |=> status_data[15:7] == 9'h000 && status_data[4:0] == 5'h00;
    endproperty
    a_grp1: assert property (p_grp1)
        else $error("group 1 spare bits not zero");
    property p_grp_zero;
        $rose(request) && (group_sel == `GRP_TWO || group_sel == `GRP_FIVE)
            |=> status_data == 16'h0000;
    endproperty
    a_grp_zero: assert property (p_grp_zero)
        else $error("group 2 or 5 word not zero");
endmodule // status_readout_chk

// ### tb.sv
`timescale 1ns/1ps
`include "status_readout_map.svh"
module tb;
    logic ref_clk, srst, root, cfg_wr, rx_req, rx_io, intx_req;
    logic nf_ev, fat_ev, fwd, rd_start;
    logic [`FN_W-1:0] cfg_fn, rx_fn, intx_fn, err_fn, rd_fn;
    logic [`GRP_W-1:0] rd_grp;
    logic [`CMD_W-1:0] cfg_cmd;
    logic [`DEVCTL_W-1:0] cfg_dc;
    logic rx_acc, rx_ur, intx_as, nf_msg, fat_msg;
    logic rd_busy, rd_valid, rd_ref, io_ok, mem_ok, mst_ok;
    logic [`DATA_W-1:0] rd_data;
    logic [`CMD_W-1:0] cmd_m [`FN_COUNT];
    logic [`DEVCTL_W-1:0] dc_m [`FN_COUNT];
    logic [2:0] flags_m;
    logic [19:0] rq[$];
    logic [4:0] sq[$];
    logic [31:0] seed;
    logic [19:0] seen_v;
    logic [19:0] exp_v;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int due = 0;

    status_readout_if port_if ();
    status_readout_dev status_readout_dev_i (.REF_CLK(ref_clk), .SRST(srst),
        .CE(1'b1), .PORT(port_if), .ROOT_MODE(root), .CFG_WR(cfg_wr),
        .CFG_WR_FN(cfg_fn), .CFG_WR_CMD(cfg_cmd), .CFG_WR_DEVCTL(cfg_dc),
        .RX_REQ(rx_req), .RX_IS_IO(rx_io), .RX_FN(rx_fn), .RX_ACCEPT(rx_acc),
        .RX_UR(rx_ur), .INTX_REQ(intx_req), .INTX_FN(intx_fn),
        .INTX_ASSERT(intx_as), .ERR_NF_EV(nf_ev), .ERR_FATAL_EV(fat_ev),
        .ERR_FWD(fwd), .ERR_FN(err_fn), .ERR_NF_MSG(nf_msg),
        .ERR_FATAL_MSG(fat_msg));
    status_readout_usr status_readout_usr_i (.REF_CLK(ref_clk), .SRST(srst),
        .CE(1'b1), .PORT(port_if), .ROOT_MODE(root), .RD_START(rd_start),
        .RD_FN(rd_fn), .RD_GROUP(rd_grp), .RD_BUSY(rd_busy),
        .RD_VALID(rd_valid), .RD_REFUSED(rd_ref), .RD_DATA(rd_data),
        .IO_TLP_OK(io_ok), .MEM_TLP_OK(mem_ok), .MASTER_OK(mst_ok));
    status_readout_chk status_readout_chk_i (.REF_CLK(ref_clk), .SRST(srst),
        .group_sel(port_if.group_sel), .func_num(port_if.func_num),
        .request(port_if.request), .status_data(port_if.status_data),
        .update_done(port_if.update_done));

    always #10 ref_clk = ~ref_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask

    // strobe stays up across calls; caller lowers it once
    task automatic cfg(input logic [2:0] f);
        logic [31:0] r;
        cfg_wr = 1'b1;
        cfg_fn = f;
        r = rnd();
        cfg_cmd = r[4:0];
        r = rnd();
        cfg_dc = r[1:0];
        cmd_m[f] = cfg_cmd;
        dc_m[f] = cfg_dc;
        step;
    endtask

    // dup re-raises start while busy; a taken duplicate underflows rq
    task automatic rd(input logic [2:0] f, input logic [2:0] g,
        input logic dup);
        logic [15:0] d;
        logic rsv;
        int k;
        rsv = !(g == `GRP_COMMAND || g == `GRP_DEVICE || g == `GRP_TWO ||
            g == `GRP_FIVE);
        d = 16'h0000;
        if (g == `GRP_COMMAND)
        begin
            d = {11'h000, cmd_m[f]};
            flags_m = cmd_m[f][2:0];
        end
        if (g == `GRP_DEVICE)
            d = {9'h000, dc_m[f], 5'h00};
        rq.push_back({rsv, flags_m[0], flags_m[1], root | flags_m[2], d});
        rd_start = 1'b1;
        rd_fn = f;
        rd_grp = g;
        step;
        rd_start = dup;
        step;
        rd_start = 1'b0;
        for (k = 0; k < 10 && rd_busy === 1'b1; k++)
            step;
        step;
    endtask

    task automatic side(input logic quiet);
        logic [31:0] r;
        logic en, okn, okf;
        r = quiet ? 32'h00000000 : rnd();
        {rx_req, rx_io, rx_fn, intx_req, intx_fn} = r[8:0];
        {nf_ev, fat_ev, fwd, err_fn} = r[21:16];
        en = cmd_m[rx_fn][rx_io ? `CMD_IO_BIT : `CMD_MEM_BIT];
        okn = fwd ? root & cmd_m[err_fn][`CMD_SERR_BIT]
            : cmd_m[err_fn][`CMD_SERR_BIT] | dc_m[err_fn][`DEVCTL_NF_BIT];
        okf = fwd ? root & cmd_m[err_fn][`CMD_SERR_BIT]
            : cmd_m[err_fn][`CMD_SERR_BIT] | dc_m[err_fn][`DEVCTL_FATAL_BIT];
        sq.push_back({rx_req & (root | en), rx_req & !root & !en,
            intx_req & !cmd_m[intx_fn][`CMD_INTX_DIS_BIT],
            nf_ev & okn, fat_ev & okf});
        step;
    endtask

    // ----------------------------------------
    // monitors
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        for (int i = 0; i < due; i++)
        begin
            seen_v = {15'h0000, rx_acc, rx_ur, intx_as, nf_msg, fat_msg};
            exp_v = {15'h0000, sq.pop_front()};
            check(seen_v, exp_v);
        end
        due = sq.size();
        if (rd_valid === 1'b1 || rd_ref === 1'b1)
        begin
            seen_v = {rd_ref, io_ok, mem_ok, mst_ok, 16'h0000};
            if (rd_valid === 1'b1)
                seen_v[15:0] = rd_data;
            exp_v = rq.size() > 0 ? rq.pop_front() : 20'hFFFFF;
            check(seen_v, exp_v);
            check({19'h00000, rd_busy}, 20'h00000);
        end
        cycles++;
        // hang guard, about seven times the expected run
        if (cycles == 8000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end

    initial
    begin
        ref_clk = 1'b0;
        srst = 1'b1;
        root = 1'b0;
        seed = 32'h00002DFD;
        flags_m = 3'h0;
        {cfg_wr, rx_req, rx_io, intx_req} = 4'h0;
        {nf_ev, fat_ev, fwd, rd_start} = 4'h0;
        {cfg_fn, rx_fn, intx_fn, err_fn, rd_fn, rd_grp} = 18'h00000;
        cfg_cmd = 5'h00;
        cfg_dc = 2'h0;
        for (int f = 0; f < `FN_COUNT; f++)
        begin
            cmd_m[f] = `CMD_RST;
            dc_m[f] = `DEVCTL_RST;
        end
        repeat (3) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        rd(3'h0, `GRP_COMMAND, 1'b0);
        for (int m = 0; m < 2; m++)
        begin
            root = m[0];
            for (int f = 0; f < `FN_COUNT; f++)
                cfg(f[2:0]);
            cfg_wr = 1'b0;
            repeat (300) side(1'b0);
            side(1'b1);
            for (int f = 0; f < `FN_COUNT; f++)
                for (int g = 0; g < 8; g++)
                    rd(f[2:0], g[2:0], g == 1);
        end
        repeat (5) step;
        wrap_up;
    end
endmodule // tb
